// ### verilog/lwf_pkg.sv
`default_nettype none
package lwf_pkg;
  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LQI_TIME_NS = 64000;
  localparam int LQI_CYCLES = LQI_TIME_NS / CLK_PERIOD_NS;
  localparam int CCA_CYCLES = 256;

  // ---------------------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int MAX_PAYLOAD = 125;
  localparam int PREAMBLE_BYTES = 4;
  localparam int FCS_BYTES = 2;
  localparam int RX_RAM_BYTES = 128;
  localparam int BUF_DEPTH = 2;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'hA7;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ---------------------------------------------------------------------------
  // spi frame: command byte then data word, msb first
  // ---------------------------------------------------------------------------
  localparam int SPI_CMD_BITS = 8;
  localparam logic [4:0] SPI_LAST_BIT = 5'h17;
  localparam logic [4:0] SPI_DATA_BIT = 5'h08;
  localparam logic [7:0] CMD_CFG = 8'h01;
  localparam logic [7:0] CMD_TX_WORD = 8'h02;
  localparam logic [7:0] CMD_TX_GO = 8'h03;
  localparam logic [7:0] CMD_RX_READ = 8'h04;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_CCA = 8'h06;
  localparam logic [7:0] CMD_CLR_PTR = 8'h07;
  localparam int CFG_STREAM_BIT = 0;

  // ---------------------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------------------
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_REQ = 1;
  localparam int ST_RX_DONE = 2;
  localparam int ST_RX_WORD = 3;
  localparam int ST_CCA_DONE = 4;
  localparam int ST_CRC_OK = 5;
  localparam int ST_STREAM = 6;
  localparam int ST_TX_BUSY = 7;
  localparam int ST_EVENTS = 5;
  localparam logic [15:0] RD_WORD_RST = 16'h0000;
endpackage
`default_nettype wire

// ### verilog/lwf_frame_transfer.sv
// Contract
// [RQ1] host control and all data pass over four-wire spi plus one interrupt line
// [RQ2] packet mode buffers whole frames; streaming mode moves one word at a time
// [RQ3] payload is at most 125 bytes; longer lengths are refused
// [RQ4] transmit sends four preamble bytes, start delimiter, length byte, then payload
// [RQ5] transmit appends a frame check sequence computed over the payload
// [RQ6] packet transmit reads the buffer; streaming transmit takes host words
// [RQ7] host loads the whole frame before issuing the transmit request
// [RQ8] packet mode interrupts once the whole frame has gone out
// [RQ9] streaming transmit interrupts for every next word until frame ends
// [RQ10] receive parses preamble, delimiter, length; stores payload and check bytes
// [RQ11] receive checks the two-byte crc and records pass or fail
// [RQ12] link quality measured 64 us after preamble, stored with the frame
// [RQ13] packet receive interrupts only when the complete frame is in
// [RQ14] streaming receive interrupts for each received data word
// [RQ15] channel assessment integrates baseband energy over a fixed window
// [RQ16] stream word is 16 bits; interrupt holds until host reads status
`timescale 1ns/1ps
`default_nettype none
module lwf_frame_transfer #(
  parameter int LQI_CYCLES = lwf_pkg::LQI_CYCLES,
  parameter int CCA_CYCLES = lwf_pkg::CCA_CYCLES,
  parameter int BUF_WIDTH = lwf_pkg::BYTE_W,
  parameter int BUF_DEPTH = lwf_pkg::BUF_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi port
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic irq,
  // modem transmit bytes
  output logic [BUF_WIDTH-1:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // modem receive bytes
  input wire logic rx_valid,
  input wire logic [lwf_pkg::BYTE_W-1:0] rx_data,
  input wire logic [lwf_pkg::BYTE_W-1:0] lqi_level,
  input wire logic [lwf_pkg::BYTE_W-1:0] cca_energy
);
  import lwf_pkg::*;

  if (BUF_DEPTH != 2 || BUF_WIDTH != BYTE_W || LQI_CYCLES < 1 ||
      CCA_CYCLES < 2 || (CCA_CYCLES & (CCA_CYCLES - 1)) != 0) begin : g_bad_cfg
    $error("lwf_frame_transfer: unsupported parameter values");
  end

  localparam int LQI_W = $clog2(LQI_CYCLES + 1);
  localparam int CCA_W = $clog2(CCA_CYCLES + 1);
  localparam int CCA_SH = $clog2(CCA_CYCLES);
  localparam int ACC_W = BYTE_W + CCA_SH;
  localparam logic [6:0] MAX_PAY_7 = 7'(MAX_PAYLOAD);

  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_PAY, TX_FCS_LO, TX_FCS_HI, TX_DRAIN} lwf_tx_t;
  typedef enum logic [1:0] {RX_HUNT, RX_LEN, RX_BODY} lwf_rx_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // ---------------------------------------------------------------------------
  // spi domain
  // ---------------------------------------------------------------------------
  logic spi_rst;
  logic [4:0] bit_cnt_q;
  logic [22:0] shift_q;
  logic [23:0] frame_q;
  logic frame_tgl_q;
  logic miso_q;
  logic [14:0] out_sh_q;
  logic [15:0] rd_word_q;

  assign spi_rst = rst | spi_ss_n;

  always_ff @(posedge spi_sclk or posedge spi_rst) begin
    if (spi_rst) begin
      bit_cnt_q <= 5'h00;
    end else if (bit_cnt_q == SPI_LAST_BIT) begin
      bit_cnt_q <= 5'h00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // capture frame and flag it across by toggle [RQ1]
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      frame_q <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[21:0], spi_mosi};
      if (!spi_ss_n && bit_cnt_q == SPI_LAST_BIT) begin
        frame_q <= {shift_q, spi_mosi};
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // answer of previous command; miso held low between frames [RQ1]
  always_ff @(negedge spi_sclk or posedge spi_rst) begin
    if (spi_rst) begin
      miso_q <= 1'b0;
      out_sh_q <= '0;
    end else if (bit_cnt_q == SPI_DATA_BIT) begin
      miso_q <= rd_word_q[15];
      out_sh_q <= rd_word_q[14:0];
    end else if (bit_cnt_q > SPI_DATA_BIT) begin
      miso_q <= out_sh_q[14];
      out_sh_q <= {out_sh_q[13:0], 1'b0};
    end else begin
      miso_q <= 1'b0;
    end
  end

  assign spi_miso = miso_q;

  // ---------------------------------------------------------------------------
  // crossing into clk domain
  // ---------------------------------------------------------------------------
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic cmd_stb;
  logic [7:0] cmd;
  logic [15:0] cmd_dat;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
    end else begin
      tgl_s1_q <= frame_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
    end
  end

  assign cmd_stb = tgl_s2_q ^ tgl_s3_q;
  assign cmd = frame_q[23:16];
  assign cmd_dat = frame_q[15:0];

  // ---------------------------------------------------------------------------
  // configuration and transmit staging
  // ---------------------------------------------------------------------------
  lwf_tx_t tx_st_q;
  logic stream_q;
  logic [7:0] tx_ram_q [MAX_PAYLOAD];
  logic [6:0] tx_wr_q;
  logic [6:0] tx_len_q;
  logic [6:0] tx_idx_q;
  logic [15:0] tx_crc_q;
  logic [15:0] sword_q;
  logic sword_v_q;
  logic [7:0] tx_byte;
  logic tx_avail;
  logic buf_in_ready;
  logic buf_push;
  logic pay_push;
  logic pay_last;
  logic tx_go;

  assign tx_go = cmd_stb && cmd == CMD_TX_GO && tx_st_q == TX_IDLE && cmd_dat <= 16'(MAX_PAYLOAD); // [RQ3]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stream_q <= 1'b0;
    end else if (cmd_stb && cmd == CMD_CFG) begin
      stream_q <= cmd_dat[CFG_STREAM_BIT]; // [RQ2]
    end
  end

  // packet buffer loaded before the start request [RQ7]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_wr_q <= 7'h00;
      for (int i = 0; i < MAX_PAYLOAD; i++) begin
        tx_ram_q[i] <= 8'h00;
      end
    end else if (cmd_stb && cmd == CMD_CLR_PTR) begin
      tx_wr_q <= 7'h00;
    end else if (cmd_stb && cmd == CMD_TX_WORD && !stream_q && tx_wr_q < MAX_PAY_7) begin
      tx_ram_q[tx_wr_q] <= cmd_dat[15:8];
      if (tx_wr_q + 7'h01 < MAX_PAY_7) begin
        tx_ram_q[tx_wr_q + 7'h01] <= cmd_dat[7:0];
      end
      tx_wr_q <= tx_wr_q + 7'h02;
    end
  end

  // streaming word holder; a new word wins over the consume [RQ16]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sword_q <= 16'h0000;
      sword_v_q <= 1'b0;
    end else begin
      if (pay_push && stream_q && (tx_idx_q[0] || pay_last)) begin
        sword_v_q <= 1'b0;
      end
      if (cmd_stb && cmd == CMD_TX_WORD && stream_q) begin
        sword_q <= cmd_dat;
        sword_v_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // transmit framer
  // ---------------------------------------------------------------------------
  assign pay_last = tx_idx_q + 7'h01 == tx_len_q;
  assign pay_push = buf_push && tx_st_q == TX_PAY;
  assign buf_push = tx_avail && buf_in_ready;

  always_comb begin
    tx_byte = PREAMBLE_BYTE;
    tx_avail = 1'b0;
    unique case (tx_st_q)
      TX_PRE: tx_avail = 1'b1; // [RQ4]
      TX_SFD: begin
        tx_byte = SFD_BYTE;
        tx_avail = 1'b1;
      end
      TX_LEN: begin
        tx_byte = {1'b0, tx_len_q} + 8'(FCS_BYTES);
        tx_avail = 1'b1;
      end
      TX_PAY: begin
        if (stream_q) begin
          tx_byte = tx_idx_q[0] ? sword_q[7:0] : sword_q[15:8]; // [RQ6]
          tx_avail = sword_v_q;
        end else begin
          tx_byte = tx_ram_q[tx_idx_q]; // [RQ6]
          tx_avail = 1'b1;
        end
      end
      TX_FCS_LO: begin
        tx_byte = tx_crc_q[7:0]; // [RQ5]
        tx_avail = 1'b1;
      end
      TX_FCS_HI: begin
        tx_byte = tx_crc_q[15:8];
        tx_avail = 1'b1;
      end
      TX_IDLE, TX_DRAIN: tx_avail = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_len_q <= 7'h00;
      tx_idx_q <= 7'h00;
      tx_crc_q <= CRC_INIT;
    end else if (tx_go) begin
      tx_st_q <= TX_PRE;
      tx_len_q <= cmd_dat[6:0];
      tx_idx_q <= 7'h00;
      tx_crc_q <= CRC_INIT;
    end else if (tx_st_q == TX_DRAIN) begin
      if (!tx_valid && buf_in_ready) begin
        tx_st_q <= TX_IDLE;
      end
    end else if (buf_push) begin
      unique case (tx_st_q)
        TX_PRE: begin
          tx_idx_q <= tx_idx_q + 7'h01;
          if (tx_idx_q == 7'(PREAMBLE_BYTES - 1)) begin // [RQ4]
            tx_st_q <= TX_SFD;
          end
        end
        TX_SFD: tx_st_q <= TX_LEN;
        TX_LEN: begin
          tx_idx_q <= 7'h00;
          tx_st_q <= (tx_len_q == 7'h00) ? TX_FCS_LO : TX_PAY;
        end
        TX_PAY: begin
          tx_crc_q <= crc_byte(tx_crc_q, tx_byte); // [RQ5]
          tx_idx_q <= tx_idx_q + 7'h01;
          if (pay_last) begin
            tx_st_q <= TX_FCS_LO;
          end
        end
        TX_FCS_LO: tx_st_q <= TX_FCS_HI;
        TX_FCS_HI: tx_st_q <= TX_DRAIN;
        TX_IDLE, TX_DRAIN: tx_st_q <= tx_st_q;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // two-entry buffer toward the modem
  // ---------------------------------------------------------------------------
  logic [BUF_WIDTH-1:0] out_q, skid_q;
  logic out_v_q, skid_v_q;

  assign buf_in_ready = !skid_v_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_q <= '0;
      skid_q <= '0;
      out_v_q <= 1'b0;
      skid_v_q <= 1'b0;
    end else if (!out_v_q || tx_ready) begin
      out_v_q <= skid_v_q || buf_push;
      out_q <= skid_v_q ? skid_q : tx_byte;
      skid_v_q <= 1'b0;
    end else if (buf_push) begin
      skid_q <= tx_byte;
      skid_v_q <= 1'b1;
    end
  end

  assign tx_data = out_q;
  assign tx_valid = out_v_q;

  // ---------------------------------------------------------------------------
  // receive parser, link quality
  // ---------------------------------------------------------------------------
  lwf_rx_t rx_st_q;
  logic [2:0] zero_cnt_q;
  logic [7:0] rx_ram_q [RX_RAM_BYTES];
  logic [6:0] rx_len_q, rx_idx_q, rx_rd_q;
  logic [15:0] rx_crc_q;
  logic crc_ok_q;
  logic [LQI_W-1:0] lqi_cnt_q;
  logic [7:0] lqi_max_q;
  logic rx_word_ev, rx_done_ev, sfd_seen;

  assign sfd_seen = rx_valid && rx_st_q == RX_HUNT && rx_data == SFD_BYTE && zero_cnt_q == 3'(PREAMBLE_BYTES);
  assign rx_done_ev = rx_valid && rx_st_q == RX_BODY && rx_idx_q + 7'h01 == rx_len_q;
  assign rx_word_ev = rx_valid && rx_st_q == RX_BODY && stream_q && rx_idx_q + 7'(FCS_BYTES) < rx_len_q &&
                      (rx_idx_q[0] || rx_idx_q + 7'(FCS_BYTES + 1) == rx_len_q); // [RQ14]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_HUNT;
      zero_cnt_q <= 3'h0;
      rx_len_q <= 7'h00;
      rx_idx_q <= 7'h00;
      rx_crc_q <= CRC_INIT;
      crc_ok_q <= 1'b0;
      for (int i = 0; i < RX_RAM_BYTES; i++) begin
        rx_ram_q[i] <= 8'h00;
      end
    end else if (rx_valid) begin
      unique case (rx_st_q)
        RX_HUNT: begin
          if (rx_data == PREAMBLE_BYTE) begin // [RQ10]
            zero_cnt_q <= (zero_cnt_q == 3'(PREAMBLE_BYTES)) ? zero_cnt_q : zero_cnt_q + 3'h1;
          end else begin
            zero_cnt_q <= 3'h0;
          end
          if (sfd_seen) begin
            rx_st_q <= RX_LEN;
          end
        end
        RX_LEN: begin
          zero_cnt_q <= 3'h0;
          rx_idx_q <= 7'h00;
          rx_crc_q <= CRC_INIT;
          if (rx_data >= 8'(FCS_BYTES) && rx_data <= 8'(MAX_PAYLOAD + FCS_BYTES)) begin // [RQ3]
            rx_len_q <= rx_data[6:0];
            rx_st_q <= RX_BODY;
          end else begin
            rx_st_q <= RX_HUNT;
          end
        end
        RX_BODY: begin
          rx_ram_q[rx_idx_q] <= rx_data; // [RQ10]
          rx_crc_q <= crc_byte(rx_crc_q, rx_data);
          rx_idx_q <= rx_idx_q + 7'h01;
          if (rx_done_ev) begin
            crc_ok_q <= crc_byte(rx_crc_q, rx_data) == 16'h0000; // [RQ11]
            rx_ram_q[rx_len_q] <= lqi_max_q; // [RQ12]
            rx_st_q <= RX_HUNT;
          end
        end
        default: rx_st_q <= RX_HUNT;
      endcase
    end
  end

  // peak level over the window after the preamble [RQ12]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lqi_cnt_q <= '0;
      lqi_max_q <= 8'h00;
    end else if (sfd_seen) begin
      lqi_cnt_q <= LQI_W'(LQI_CYCLES);
      lqi_max_q <= 8'h00;
    end else if (lqi_cnt_q != '0) begin
      lqi_cnt_q <= lqi_cnt_q - LQI_W'(1);
      if (lqi_level > lqi_max_q) begin
        lqi_max_q <= lqi_level;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // channel assessment
  // ---------------------------------------------------------------------------
  logic [CCA_W-1:0] cca_cnt_q;
  logic [ACC_W-1:0] cca_acc_q, cca_sum;
  logic [7:0] cca_lvl_q;
  logic cca_done_ev;

  assign cca_sum = cca_acc_q + ACC_W'(cca_energy);
  assign cca_done_ev = cca_cnt_q == CCA_W'(1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cca_cnt_q <= '0;
      cca_acc_q <= '0;
      cca_lvl_q <= 8'h00;
    end else if (cmd_stb && cmd == CMD_CCA) begin
      cca_cnt_q <= CCA_W'(CCA_CYCLES);
      cca_acc_q <= '0;
    end else if (cca_cnt_q != '0) begin
      cca_cnt_q <= cca_cnt_q - CCA_W'(1);
      cca_acc_q <= cca_sum; // [RQ15]
      if (cca_done_ev) begin
        cca_lvl_q <= cca_sum[ACC_W-1:CCA_SH];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // status, interrupt, host reads
  // ---------------------------------------------------------------------------
  logic [ST_EVENTS-1:0] flags_q, flags_set, flags_d;
  logic irq_q;
  logic stat_rd;

  assign stat_rd = cmd_stb && cmd == CMD_STATUS;

  always_comb begin
    flags_set = '0;
    flags_set[ST_TX_DONE] = tx_st_q == TX_DRAIN && !tx_valid && buf_in_ready; // [RQ8]
    flags_set[ST_TX_REQ] = stream_q && (tx_go || (pay_push && tx_idx_q[0] && !pay_last)); // [RQ9]
    flags_set[ST_RX_DONE] = rx_done_ev; // [RQ13]
    flags_set[ST_RX_WORD] = rx_word_ev; // [RQ14]
    flags_set[ST_CCA_DONE] = cca_done_ev;
    flags_d = (flags_q & ~(stat_rd ? flags_q : '0)) | flags_set;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
      irq_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_q <= |flags_d; // [RQ16]
    end
  end

  assign irq = irq_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_word_q <= RD_WORD_RST;
      rx_rd_q <= 7'h00;
    end else if (rx_valid && rx_st_q == RX_LEN) begin
      rx_rd_q <= 7'h00;
    end else if (cmd_stb) begin
      if (cmd == CMD_STATUS) begin
        rd_word_q <= {cca_lvl_q, tx_st_q != TX_IDLE, stream_q, crc_ok_q, flags_q};
      end else if (cmd == CMD_RX_READ) begin
        rd_word_q <= {rx_ram_q[rx_rd_q], rx_ram_q[rx_rd_q + 7'h01]}; // [RQ16]
        rx_rd_q <= rx_rd_q + 7'h02;
      end else if (cmd == CMD_CLR_PTR) begin
        rx_rd_q <= 7'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/lwf_frame_transfer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module lwf_frame_transfer_properties
  import lwf_pkg::*;
#(
  parameter int BUF_WIDTH = BYTE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // spi port
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_miso,
  input wire logic irq,
  // modem transmit bytes
  input wire logic [BUF_WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready
);
  logic acc;
  logic [7:0] rem_q;
  logic [2:0] run_q;
  logic aft_q;
  logic [3:0] sel_q;
  logic [4:0] bit_q;
  assign acc = tx_valid && tx_ready;

  // ---------------------------------------------------------------------------
  // frame position seen on the byte stream
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_q <= 8'h00;
      run_q <= 3'h0;
      aft_q <= 1'b0;
    end else if (acc) begin
      aft_q <= (rem_q == 8'h00) && (run_q == 3'h4) && (tx_data[7:0] == SFD_BYTE);
      if (aft_q) begin
        rem_q <= tx_data[7:0];
      end else if (rem_q != 8'h00) begin
        rem_q <= rem_q - 8'h01;
      end
      if (rem_q == 8'h00 && !aft_q && tx_data[7:0] == PREAMBLE_BYTE && run_q != 3'h4) begin
        run_q <= run_q + 3'h1;
      end else begin
        run_q <= 3'h0;
      end
    end
  end

  // cycles since the host last selected the port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= 4'h0;
    end else if (!spi_ss_n) begin
      sel_q <= 4'h0;
    end else if (sel_q != 4'hF) begin
      sel_q <= sel_q + 4'h1;
    end
  end

  always_ff @(posedge spi_sclk or posedge spi_ss_n) begin
    if (spi_ss_n) begin
      bit_q <= 5'h00;
    end else if (bit_q != 5'h1F) begin
      bit_q <= bit_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  sequence s_last_byte;
    acc && rem_q == 8'h01;
  endsequence
  sequence s_irq_soon;
    ##[1:4] irq;
  endsequence

  a_txv_hold: assert property (@(posedge clk) disable iff (rst) tx_valid && !tx_ready |=> tx_valid)
    else $error("byte valid dropped before acceptance");
  a_txd_stable: assert property (@(posedge clk) disable iff (rst)
    tx_valid && !tx_ready |=> $stable(tx_data)) else $error("byte changed while stalled");
  a_reset_quiet: assert property (@(posedge clk) disable iff (rst) $fell(rst) |-> !irq && !tx_valid)
    else $error("outputs active after reset");
  a_miso_idle: assert property (@(posedge clk) disable iff (rst)
    spi_ss_n && $past(spi_ss_n) |-> !spi_miso) else $error("miso high while deselected");
  a_miso_cmd: assert property (@(posedge spi_sclk) disable iff (spi_ss_n) bit_q < 5'h08 |-> !spi_miso)
    else $error("miso high during command byte");
  a_irq_hold: assert property (@(posedge clk) disable iff (rst) irq && sel_q == 4'hF |=> irq)
    else $error("interrupt dropped without host access");
  a_sfd_after_pre: assert property (@(posedge clk) disable iff (rst)
    acc && rem_q == 8'h00 && run_q == 3'h4 |-> tx_data[7:0] == SFD_BYTE) else $error("no delimiter after preamble");
  a_len_range: assert property (@(posedge clk) disable iff (rst)
    acc && aft_q |-> tx_data[7:0] >= 8'h02 && tx_data[7:0] <= 8'h7F) else $error("length byte out of range");
  a_done_irq: assert property (@(posedge clk) disable iff (rst) s_last_byte |-> s_irq_soon)
    else $error("no interrupt after frame end");
endmodule

bind lwf_frame_transfer lwf_frame_transfer_properties #(.BUF_WIDTH(BUF_WIDTH)) chk (
  .clk(clk),
  .rst(rst),
  .spi_sclk(spi_sclk),
  .spi_ss_n(spi_ss_n),
  .spi_miso(spi_miso),
  .irq(irq),
  .tx_data(tx_data),
  .tx_valid(tx_valid),
  .tx_ready(tx_ready)
);
`default_nettype wire

// ### testbench/lwf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lwf_host_model (
  // spi pins
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // one 24-bit frame; returns the answer to the previous command
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat, output logic [15:0] rd);
    logic [23:0] w;
    w = {cmd, dat};
    rd = 16'h0000;
    ss_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      mosi = w[i];
      #16;
      sclk = 1'b1;
      if (i < 16) rd[i] = miso;
      #16;
      sclk = 1'b0;
    end
    #8;
    ss_n = 1'b1;
    mosi = ~mosi;
    #120;
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import lwf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tx_ready = 1'b0;
  logic rx_valid = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] lqi_level = 8'h00;
  logic [7:0] cca_energy = 8'h00;
  wire logic sclk, ss_n, mosi;
  logic miso, irq, tx_valid;
  logic [7:0] tx_data;
  logic [7:0] exp_q[$];
  logic [7:0] e8;
  logic [15:0] s, d;
  int num_errors = 0;
  int checks = 0;

  always #5 clk = ~clk;

  lwf_frame_transfer #(.LQI_CYCLES(16), .CCA_CYCLES(4)) dut (
    .clk(clk), .rst(rst), .spi_sclk(sclk), .spi_ss_n(ss_n), .spi_mosi(mosi), .spi_miso(miso), .irq(irq),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .lqi_level(lqi_level), .cca_energy(cca_energy));
  lwf_host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  // modem stalls at random
  always @(negedge clk) tx_ready <= ($urandom % 4) != 0;

  // ---------------------------------------------------------------------------
  // byte stream scoreboard
  // ---------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      e8 = exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX;
      `CHK("tx byte", e8, tx_data)
    end
  end

  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  task automatic wait_irq();
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk);
    `CHK("irq", 1'b1, irq)
  endtask

  task automatic get_status(output logic [15:0] st);
    logic [15:0] t;
    host.xfer(CMD_STATUS, 16'h0000, t);
    host.xfer(CMD_STATUS, 16'h0000, st);
  endtask

  task automatic send_tx(input int n, input logic strm);
    logic [7:0] p[$];
    logic [15:0] c;
    p = {};
    for (int i = 0; i < n; i++) p.push_back(8'($urandom));
    c = crc(p);
    exp_q = {PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, SFD_BYTE, 8'(n + 2)};
    foreach (p[i]) exp_q.push_back(p[i]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(c[15:8]);
    if (n % 2) p.push_back(8'h00);
    host.xfer(CMD_CFG, {15'h0000, strm}, d);
    host.xfer(CMD_CLR_PTR, 16'h0000, d);
    if (!strm) for (int i = 0; i < n; i += 2) host.xfer(CMD_TX_WORD, {p[i], p[i+1]}, d);
    host.xfer(CMD_TX_GO, 16'(n), d);
    if (strm) for (int i = 0; i < n; i += 2) begin
      wait_irq();
      get_status(s);
      `CHK("tx req", 1'b1, s[ST_TX_REQ])
      host.xfer(CMD_TX_WORD, {p[i], p[i+1]}, d);
    end
    for (int k = 0; k < 20000 && exp_q.size() != 0; k++) @(negedge clk);
    `CHK("tx left", 0, exp_q.size())
    wait_irq();
    get_status(s);
    `CHK("tx done", 1'b1, s[ST_TX_DONE])
    `CHK("tx req end", 1'b0, s[ST_TX_REQ])
    `CHK("irq clr", 1'b0, irq)
  endtask

  task automatic send_rx(input int n, input logic bad, input logic strm);
    logic [7:0] f[$];
    logic [7:0] air[$];
    logic [15:0] c;
    f = {};
    for (int i = 0; i < n; i++) f.push_back(8'($urandom));
    c = crc(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    air = {PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, PREAMBLE_BYTE, SFD_BYTE, 8'(n + 2)};
    foreach (f[i]) air.push_back(f[i]);
    f.push_back(8'($urandom));
    host.xfer(CMD_CFG, {15'h0000, strm}, d);
    @(negedge clk);
    lqi_level <= f[n + 2];
    foreach (air[i]) begin
      if (strm && i == 8) begin
        wait_irq();
        get_status(s);
        `CHK("rx word", 1'b1, s[ST_RX_WORD])
      end
      if (!strm && i == air.size() - 1) `CHK("irq early", 1'b0, irq)
      @(negedge clk);
      rx_valid <= 1'b1;
      rx_data <= air[i];
      @(negedge clk);
      rx_valid <= 1'b0;
      repeat (2) @(negedge clk);
    end
    wait_irq();
    get_status(s);
    `CHK("rx done", 1'b1, s[ST_RX_DONE])
    `CHK("crc ok", !bad, s[ST_CRC_OK])
    `CHK("rx word end", strm, s[ST_RX_WORD])
    if (!strm) begin
      host.xfer(CMD_CLR_PTR, 16'h0000, d);
      host.xfer(CMD_RX_READ, 16'h0000, d);
      for (int p = 0; p < n + 3; p += 2) begin
        host.xfer(p + 2 < n + 3 ? CMD_RX_READ : CMD_STATUS, 16'h0000, d);
        `CHK("rx ram", {f[p], f[p+1]}, d)
      end
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #600000;
    num_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'hAEBFF9AF));
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    @(negedge clk);
    get_status(s);
    send_tx(125, 1'b0);
    send_tx(5, 1'b1);
    host.xfer(CMD_CFG, 16'h0000, d);
    host.xfer(CMD_TX_GO, 16'h007E, d);
    host.xfer(CMD_TX_GO, 16'h0080, d);
    repeat (60) @(negedge clk);
    `CHK("refused go", 1'b0, irq)
    get_status(s);
    `CHK("refused busy", 1'b0, s[ST_TX_BUSY])
    send_rx(5, 1'b0, 1'b0);
    send_rx(7, 1'b1, 1'b0);
    send_rx(4, 1'b0, 1'b1);
    @(negedge clk);
    cca_energy <= 8'($urandom);
    host.xfer(CMD_CCA, 16'h0000, d);
    wait_irq();
    get_status(s);
    `CHK("cca", {cca_energy, 1'b1}, {s[15:8], s[ST_CCA_DONE]})
    give_verdict();
  end
endmodule
`default_nettype wire
